// ---- verilog/dfx_dev.sv ----
// Effects filter chain: de-emphasis, two biquads per channel, 3-D mix,
// soft-mute around processing changes, modulator rate tick.
// Assumes samples and control from the controller end on the same clock.
// Operation
// - First-order filter per channel, normalised 32768
// - First-order coefficients fully programmable
// - Reset loads 48 kHz de-emphasis set
// - Host loads 32 kHz de-emphasis set
// - Host loads 44.1 kHz de-emphasis set
// - Two cascaded biquads per channel
// - Biquad doubles middle terms, normalised 32768
// - Section one group one, section two group two
// - Effects filter enable or bypass
// - Coefficients are 16-bit two's complement
// - Reset loads shelving biquad coefficients
// - 3-D mode filters mono mix, adds back
// - Programmable attenuation scales 3-D contribution
// - Host disables filters before coefficient rewrite
// - Modulator tick at 128 times reference rate
// - Double rate without PLL: dividers 4,8,9,12,16
// - Soft-mute, switch processing, soft-unmute
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module dfx_dev #(
    parameter int MOD_DIV = dfx_pkg::MOD_DIV_CYC
) (
    input wire logic ref_clk,
    input wire logic srst,
    dfx_if.dev lnk
);
    import dfx_pkg::*;

    generate
        if (MOD_DIV < 2 || MOD_DIV > 255) begin : g_bad_div
            $error("MOD_DIV out of range");
        end
    endgenerate

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_DL = 8'h02,
        ST_DR = 8'h04,
        ST_B1 = 8'h08,
        ST_B2 = 8'h10,
        ST_B3 = 8'h20,
        ST_B4 = 8'h40,
        ST_OUT = 8'h80
    } dfx_state_e;

    dfx_state_e state_q;
    dfx_state_e state_d;
    logic [COEF_W-1:0] coef_q [COEF_N];
    dfx_smp_t x1_q [6];
    dfx_smp_t x2_q [6];
    dfx_smp_t y1_q [6];
    dfx_smp_t y2_q [6];
    dfx_smp_t xl_q;
    dfx_smp_t xr_q;
    logic de_on_q;
    logic eff_on_q;
    logic td_on_q;
    logic [VOL_W-1:0] vol_q;
    logic [7:0] div_q;
    logic tick_q;
    logic busy_q;
    logic ov_q;
    dfx_smp_t ol_q;
    dfx_smp_t or_q;

    // Coefficient base of each stage: 0/1 de-emphasis, 2..5 sections
    function automatic logic [COEF_AW-1:0] stage_base(input logic [2:0] s);
        unique case (s)
            3'd0: stage_base = COEF_AW'(OFS_DE);
            3'd1: stage_base = COEF_AW'(COEF_PER_CH + OFS_DE);
            3'd2: stage_base = COEF_AW'(OFS_S1);
            3'd3: stage_base = COEF_AW'(OFS_S2);
            3'd4: stage_base = COEF_AW'(COEF_PER_CH + OFS_S1);
            default: stage_base = COEF_AW'(COEF_PER_CH + OFS_S2);
        endcase
    endfunction

    wire [2:0] stg = (state_q == ST_DR) ? 3'd1 :
                     (state_q == ST_B1) ? 3'd2 :
                     (state_q == ST_B2) ? 3'd3 :
                     (state_q == ST_B3) ? 3'd4 :
                     (state_q == ST_B4) ? 3'd5 : 3'd0;
    wire is_de = (stg < 3'd2);
    wire [COEF_AW-1:0] cb = stage_base(stg);
    wire dfx_smp_t dl = y1_q[0];
    wire dfx_smp_t dr = y1_q[1];
    // Mono mix of the de-emphasised pair
    wire dfx_smp_t mono = sat_s((40'(dl) + 40'(dr)) >>> 1);

    // Section chain feeds: group one then group two
    wire dfx_smp_t sx = (state_q == ST_DL) ? xl_q :
                        (state_q == ST_DR) ? xr_q :
                        (state_q == ST_B1) ? (td_on_q ? mono : dl) :
                        (state_q == ST_B2) ? y1_q[2] :
                        (state_q == ST_B3) ? dr : y1_q[4];

    // First-order taps: n0, n1, d1 with no second-order terms
    wire dfx_coef_t c0 = coef_q[cb];
    wire dfx_coef_t c1 = coef_q[cb + 5'd1];
    wire dfx_coef_t c2 = is_de ? 16'h0000 : coef_q[cb + 5'd2];
    wire dfx_coef_t c3 = is_de ? coef_q[cb + 5'd2] : coef_q[cb + 5'd3];
    wire dfx_coef_t c4 = is_de ? 16'h0000 : coef_q[cb + 5'd4];
    wire dfx_smp_t sy;

    // Doubled middle terms only in biquads
    dfx_sect u_sect (
        .x(sx),
        .x1(x1_q[stg]),
        .x2(x2_q[stg]),
        .y1(y1_q[stg]),
        .y2(y2_q[stg]),
        .c0(c0),
        .c1(c1),
        .c2(c2),
        .c3(c3),
        .c4(c4),
        .dbl(!is_de),
        .y(sy)
    );

    // Bypass passes the stage input unchanged
    wire bypass = is_de ? !de_on_q : !(eff_on_q || td_on_q);
    wire dfx_smp_t stage_y = bypass ? sx : sy;
    wire run_stage = (state_q != ST_IDLE) && (state_q != ST_OUT);

    wire signed [20:0] td_m = y1_q[3] * $signed({1'b0, lnk.atten});
    wire signed [39:0] td_c = 40'(td_m) >>> ATT_W;
    wire dfx_smp_t pre_l = td_on_q ? sat_s(40'(dl) + td_c) :
                           eff_on_q ? y1_q[3] : dl;
    wire dfx_smp_t pre_r = td_on_q ? sat_s(40'(dr) + td_c) :
                           eff_on_q ? y1_q[5] : dr;
    wire signed [24:0] g_l = pre_l * $signed({1'b0, vol_q});
    wire signed [24:0] g_r = pre_r * $signed({1'b0, vol_q});
    wire pend = (lnk.deemph_req != de_on_q) || (lnk.eff_req != eff_on_q) ||
                (lnk.td_req != td_on_q);
    wire take = (state_q == ST_IDLE) && lnk.in_valid;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: state_d = lnk.in_valid ? ST_DL : ST_IDLE;
            ST_DL: state_d = ST_DR;
            ST_DR: state_d = ST_B1;
            ST_B1: state_d = ST_B2;
            ST_B2: state_d = ST_B3;
            ST_B3: state_d = ST_B4;
            ST_B4: state_d = ST_OUT;
            ST_OUT: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Defaults at reset, any value later
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < COEF_N; i++) begin
                coef_q[i] <= coef_rst(i);
            end
        end else if (lnk.coef_we && lnk.coef_addr < COEF_AW'(COEF_N)) begin
            coef_q[lnk.coef_addr] <= lnk.coef_data;
        end
    end

    // Per-stage state of the recursive sections
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < 6; i++) begin
                x1_q[i] <= '0;
                x2_q[i] <= '0;
                y1_q[i] <= '0;
                y2_q[i] <= '0;
            end
        end else if (run_stage) begin
            x2_q[stg] <= x1_q[stg];
            x1_q[stg] <= sx;
            y2_q[stg] <= y1_q[stg];
            y1_q[stg] <= stage_y;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            xl_q <= '0;
            xr_q <= '0;
        end else if (take) begin
            xl_q <= lnk.in_l;
            xr_q <= lnk.in_r;
        end
    end

    // Ramp down, switch at silence, ramp back up
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            de_on_q <= 1'b0;
            eff_on_q <= 1'b0;
            td_on_q <= 1'b0;
            vol_q <= '0;
        end else if (state_q == ST_OUT) begin
            if (pend && vol_q == '0) begin
                de_on_q <= lnk.deemph_req;
                eff_on_q <= lnk.eff_req;
                td_on_q <= lnk.td_req;
            end else if (pend) begin
                vol_q <= vol_q - 8'h01;
            end else if (vol_q < VOL_FULL) begin
                vol_q <= vol_q + 8'h01;
            end
        end
    end

    // Output gain clips at full scale
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ov_q <= 1'b0;
            ol_q <= '0;
            or_q <= '0;
            busy_q <= 1'b0;
        end else begin
            ov_q <= (state_q == ST_OUT);
            busy_q <= take || (busy_q && state_q != ST_OUT);
            if (state_q == ST_OUT) begin
                ol_q <= sat_s(40'(g_l) >>> VOL_SHIFT);
                or_q <= sat_s(40'(g_r) >>> VOL_SHIFT);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == 8'(MOD_DIV - 1));
            div_q <= (div_q == 8'(MOD_DIV - 1)) ? 8'h00 : div_q + 8'h01;
        end
    end

    assign lnk.out_valid = ov_q;
    assign lnk.out_l = ol_q;
    assign lnk.out_r = or_q;
    assign lnk.busy = busy_q;
    assign lnk.deemph_on = de_on_q;
    assign lnk.eff_on = eff_on_q;
    assign lnk.td_on = td_on_q;
    assign lnk.vol_full = (vol_q == VOL_FULL) && !pend;
    assign lnk.mod_tick = tick_q;
endmodule

// ---- include/dfx_pkg.sv ----
// Shared constants, types and helpers of the effects filter chain.
// Assumes one 125 MHz clock and 16-bit signed audio samples.
package dfx_pkg;
    localparam int SAMPLE_W = 16;
    localparam int COEF_W = 16;
    localparam int COEF_AW = 5;
    localparam int COEF_N = 26;
    localparam int COEF_PER_CH = 13;
    localparam int OFS_DE = 0;
    localparam int OFS_S1 = 3;
    localparam int OFS_S2 = 8;
    localparam int NORM_SHIFT = 15;
    localparam int ATT_W = 4;
    localparam int VOL_W = 8;
    localparam logic [VOL_W-1:0] VOL_FULL = 8'h80;
    localparam int VOL_SHIFT = 7;
    localparam longint CLK_HZ = 125000000;
    localparam longint FSREF_HZ = 48000;
    localparam longint MOD_OSR = 128;
    localparam int MOD_DIV_CYC = int'(CLK_HZ / (MOD_OSR * FSREF_HZ));
    // Reset coefficient sets
    localparam logic [15:0] DE_N0_RST = 16'h3955;
    localparam logic [15:0] DE_N1_RST = 16'hF32D;
    localparam logic [15:0] DE_D1_RST = 16'h537E;
    localparam logic [15:0] BQ_B0_RST = 16'h6BE3;
    localparam logic [15:0] BQ_B1_RST = 16'h9666;
    localparam logic [15:0] BQ_B2_RST = 16'h675D;
    localparam logic [15:0] BQ_A1_RST = 16'h7D83;
    localparam logic [15:0] BQ_A2_RST = 16'h84EE;
    // De-emphasis presets for 32 kHz and 44.1 kHz
    localparam logic [15:0] DE32_N0 = 16'h4236;
    localparam logic [15:0] DE32_N1 = 16'hFB3C;
    localparam logic [15:0] DE32_D1 = 16'h428D;
    localparam logic [15:0] DE44_N0 = 16'h3AF3;
    localparam logic [15:0] DE44_N1 = 16'hF4C3;
    localparam logic [15:0] DE44_D1 = 16'h504B;
    // Controller register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_COEF = 8'h04;
    localparam logic [7:0] REG_SAMPLE = 8'h08;
    localparam logic [7:0] REG_OUT = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_PRESET = 8'h14;
    localparam logic [7:0] REG_CLKCFG = 8'h18;
    localparam logic [5:0] PLL_K_HI = 6'h10;
    localparam logic [5:0] PLL_K_LO = 6'h08;

    typedef logic signed [SAMPLE_W-1:0] dfx_smp_t;
    typedef logic signed [COEF_W-1:0] dfx_coef_t;

    function automatic logic [15:0] coef_rst(input int idx);
        unique case (idx % COEF_PER_CH)
            0: coef_rst = DE_N0_RST;
            1: coef_rst = DE_N1_RST;
            2: coef_rst = DE_D1_RST;
            3, 8: coef_rst = BQ_B0_RST;
            4, 9: coef_rst = BQ_B1_RST;
            5, 10: coef_rst = BQ_B2_RST;
            6, 11: coef_rst = BQ_A1_RST;
            default: coef_rst = BQ_A2_RST;
        endcase
    endfunction

    // Clip to the sample range instead of wrapping
    function automatic dfx_smp_t sat_s(input logic signed [39:0] v);
        if (v > 40'sh0000007FFF) begin
            sat_s = 16'h7FFF;
        end else if (v < -40'sh0000008000) begin
            sat_s = 16'h8000;
        end else begin
            sat_s = v[SAMPLE_W-1:0];
        end
    endfunction
endpackage

// ---- include/dfx_if.sv ----
// Link between the effects filter chain and its controller.
// Both ends run on the same ref_clk; every signal is a level or one-cycle pulse.
`timescale 1ns/10ps
interface dfx_if;
    import dfx_pkg::*;
    logic coef_we;
    logic [COEF_AW-1:0] coef_addr;
    logic [COEF_W-1:0] coef_data;
    logic deemph_req;
    logic eff_req;
    logic td_req;
    logic [ATT_W-1:0] atten;
    logic in_valid;
    dfx_smp_t in_l;
    dfx_smp_t in_r;
    logic out_valid;
    dfx_smp_t out_l;
    dfx_smp_t out_r;
    logic busy;
    logic deemph_on;
    logic eff_on;
    logic td_on;
    logic vol_full;
    logic mod_tick;
    modport dev (
        input coef_we, coef_addr, coef_data, deemph_req, eff_req, td_req, atten,
        input in_valid, in_l, in_r,
        output out_valid, out_l, out_r, busy, deemph_on, eff_on, td_on, vol_full,
        output mod_tick
    );
    modport host (
        output coef_we, coef_addr, coef_data, deemph_req, eff_req, td_req, atten,
        output in_valid, in_l, in_r,
        input out_valid, out_l, out_r, busy, deemph_on, eff_on, td_on, vol_full,
        input mod_tick
    );
endinterface

// ---- verilog/dfx_sect.sv ----
// One filter section: five products, doubling of the middle terms, /32768.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module dfx_sect (
    input wire dfx_pkg::dfx_smp_t x,
    input wire dfx_pkg::dfx_smp_t x1,
    input wire dfx_pkg::dfx_smp_t x2,
    input wire dfx_pkg::dfx_smp_t y1,
    input wire dfx_pkg::dfx_smp_t y2,
    input wire dfx_pkg::dfx_coef_t c0,
    input wire dfx_pkg::dfx_coef_t c1,
    input wire dfx_pkg::dfx_coef_t c2,
    input wire dfx_pkg::dfx_coef_t c3,
    input wire dfx_pkg::dfx_coef_t c4,
    input wire logic dbl,
    output wire dfx_pkg::dfx_smp_t y
);
    import dfx_pkg::*;
    wire signed [31:0] m0 = c0 * x;
    wire signed [31:0] m1 = c1 * x1;
    wire signed [31:0] m2 = c2 * x2;
    wire signed [31:0] m3 = c3 * y1;
    wire signed [31:0] m4 = c4 * y2;
    wire signed [39:0] t1 = dbl ? (40'(m1) <<< 1) : 40'(m1);
    wire signed [39:0] t3 = dbl ? (40'(m3) <<< 1) : 40'(m3);
    // Wide accumulator so only the final value clips
    wire signed [39:0] acc = 40'(m0) + t1 + 40'(m2) + t3 + 40'(m4);
    assign y = sat_s(acc >>> NORM_SHIFT);
endmodule

// ---- verilog/dfx_host.sv ----
// Controller end: software register port, coefficient and preset loading,
// sample hand-off and clock divider planning.
// Assumes software obeys the one-cycle strobe protocol of the register port.
`timescale 1ns/10ps
module dfx_host (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    output logic [4:0] clk_div,
    output logic pll_en,
    output logic [2:0] pll_p,
    output logic [5:0] pll_k,
    dfx_if.host lnk
);
    import dfx_pkg::*;

    logic [7:0] ctrl_q;
    logic [5:0] clkcfg_q;
    logic cwe_q;
    logic [COEF_AW-1:0] caddr_q;
    logic [COEF_W-1:0] cdata_q;
    logic inv_q;
    dfx_smp_t il_q;
    dfx_smp_t ir_q;
    logic [31:0] out_q;
    logic [31:0] rdata_q;
    logic refused_q;
    logic overrun_q;
    logic cfgerr_q;
    logic [2:0] ld_q;
    logic [1:0] pre_q;

    wire wr_ctrl = sw_wr && sw_addr == REG_CTRL;
    wire wr_coef = sw_wr && sw_addr == REG_COEF;
    wire wr_smp = sw_wr && sw_addr == REG_SAMPLE;
    wire wr_pre = sw_wr && sw_addr == REG_PRESET;
    wire wr_clk = sw_wr && sw_addr == REG_CLKCFG;
    wire rd_stat = sw_rd && sw_addr == REG_STATUS;
    // Coefficients change only with all filters switched off
    wire filt_off = !(ctrl_q[0] || ctrl_q[1] || ctrl_q[2]) &&
                    !(lnk.deemph_on || lnk.eff_on || lnk.td_on);
    wire loading = (ld_q != 3'd0);
    wire coef_ok = filt_off && !loading;
    wire smp_ok = !lnk.busy && !inv_q;

    // De-emphasis presets; index 2 gives the 48 kHz set
    function automatic logic [15:0] preset(input logic [1:0] p, input logic [1:0] k);
        logic [15:0] n0;
        logic [15:0] n1;
        logic [15:0] d1;
        n0 = (p == 2'd0) ? DE32_N0 : (p == 2'd1) ? DE44_N0 : DE_N0_RST;
        n1 = (p == 2'd0) ? DE32_N1 : (p == 2'd1) ? DE44_N1 : DE_N1_RST;
        d1 = (p == 2'd0) ? DE32_D1 : (p == 2'd1) ? DE44_D1 : DE_D1_RST;
        preset = (k == 2'd0) ? n0 : (k == 2'd1) ? n1 : d1;
    endfunction

    // Loader steps 6..1: right d1,n1,n0 then left d1,n1,n0
    wire [2:0] ls = ld_q - 3'd1;
    wire [1:0] lk = (ls >= 3'd3) ? 2'(ls - 3'd3) : 2'(ls);
    wire [COEF_AW-1:0] la = (ls >= 3'd3) ? COEF_AW'(COEF_PER_CH + OFS_DE) + 5'(lk) :
                                           COEF_AW'(OFS_DE) + 5'(lk);

    // Divider or PLL plan, bit 15 = not allowed
    function automatic logic [15:0] clk_plan(input logic [4:0] q, input logic dbl);
        clk_plan = {1'b0, 9'h000, q, 1'b0};
        if (dbl) begin
            unique case (q)
                5'd4, 5'd8, 5'd9, 5'd12, 5'd16: clk_plan = {1'b0, 9'h000, q, 1'b0};
                5'd5, 5'd6, 5'd7: clk_plan = {1'b0, PLL_K_HI, q[2:0], q, 1'b1};
                5'd10, 5'd14: clk_plan = {1'b0, PLL_K_LO, q[3:1], q, 1'b1};
                default: clk_plan = 16'h8000;
            endcase
        end
    endfunction
    wire [15:0] plan = clk_plan(sw_wdata[4:0], sw_wdata[5]);

    wire [31:0] status = {24'h000000, cfgerr_q, overrun_q, refused_q, lnk.busy,
                          lnk.vol_full, lnk.td_on, lnk.eff_on, lnk.deemph_on};
    wire [31:0] rd_mux = (sw_addr == REG_CTRL) ? {24'h000000, ctrl_q} :
                         (sw_addr == REG_OUT) ? out_q :
                         (sw_addr == REG_STATUS) ? status :
                         (sw_addr == REG_CLKCFG) ? {26'h0000000, clkcfg_q} : 32'h00000000;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_q <= '0;
            rdata_q <= '0;
            out_q <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= {sw_wdata[7:4], 1'b0, sw_wdata[2:0]};
            end
            rdata_q <= sw_rd ? rd_mux : 32'h00000000;
            if (lnk.out_valid) begin
                out_q <= {lnk.out_l, lnk.out_r};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cwe_q <= 1'b0;
            caddr_q <= '0;
            cdata_q <= '0;
            ld_q <= 3'd0;
            pre_q <= 2'd2;
        end else begin
            cwe_q <= 1'b0;
            if (loading) begin
                cwe_q <= 1'b1;
                caddr_q <= la;
                cdata_q <= preset(pre_q, lk);
                ld_q <= ld_q - 3'd1;
            end else if (wr_pre && coef_ok) begin
                ld_q <= 3'd6;
                pre_q <= sw_wdata[1:0];
            end else if (wr_coef && coef_ok) begin
                cwe_q <= 1'b1;
                caddr_q <= sw_wdata[20:16];
                cdata_q <= sw_wdata[15:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            inv_q <= 1'b0;
            il_q <= '0;
            ir_q <= '0;
        end else begin
            inv_q <= wr_smp && smp_ok;
            if (wr_smp && smp_ok) begin
                il_q <= sw_wdata[31:16];
                ir_q <= sw_wdata[15:0];
            end
        end
    end

    // Sticky errors: a new event wins over the clearing read
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            refused_q <= 1'b0;
            overrun_q <= 1'b0;
            cfgerr_q <= 1'b0;
        end else begin
            refused_q <= ((wr_coef || wr_pre) && !coef_ok) || (refused_q && !rd_stat);
            overrun_q <= (wr_smp && !smp_ok) || (overrun_q && !rd_stat);
            cfgerr_q <= (wr_clk && plan[15]) || (cfgerr_q && !rd_stat);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            clkcfg_q <= '0;
            clk_div <= '0;
            pll_en <= 1'b0;
            pll_p <= '0;
            pll_k <= '0;
        end else if (wr_clk && !plan[15]) begin
            clkcfg_q <= sw_wdata[5:0];
            pll_en <= plan[0];
            clk_div <= plan[5:1];
            pll_p <= plan[8:6];
            pll_k <= plan[14:9];
        end
    end

    assign sw_rdata = rdata_q;
    assign lnk.coef_we = cwe_q;
    assign lnk.coef_addr = caddr_q;
    assign lnk.coef_data = cdata_q;
    assign lnk.deemph_req = ctrl_q[0];
    assign lnk.eff_req = ctrl_q[1];
    assign lnk.td_req = ctrl_q[2];
    assign lnk.atten = ctrl_q[7:4];
    assign lnk.in_valid = inv_q;
    assign lnk.in_l = il_q;
    assign lnk.in_r = ir_q;
endmodule

// ---- verification/dfx_link_properties.sv ----
// Concurrent checks on the link between filter chain and controller.
// Assumes one clock ref_clk and synchronous active-high srst.
`timescale 1ns/10ps
module dfx_link_properties #(
    parameter int MOD_DIV = 2
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic in_valid,
    input wire logic out_valid,
    input wire dfx_pkg::dfx_smp_t out_l,
    input wire logic busy,
    input wire logic deemph_req,
    input wire logic eff_req,
    input wire logic deemph_on,
    input wire logic eff_on,
    input wire logic vol_full,
    input wire logic mod_tick
);
    import dfx_pkg::*;
    logic [7:0] gap_q;
    logic seen_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // First tick after reset has arbitrary phase, so it is skipped
    always_ff @(posedge ref_clk) begin
        gap_q <= (srst || mod_tick) ? 8'h00 : gap_q + 8'h01;
        seen_q <= !srst && (seen_q || mod_tick);
    end
    a_take_answer: assert property (in_valid && !busy |-> ##8 out_valid)
        else $error("no output 8 cycles after take");
    a_busy_span: assert property (in_valid && !busy |=> busy[*7] ##1 !busy)
        else $error("busy span wrong");
    a_out_pulse: assert property (out_valid |=> !out_valid && $past(busy, 2))
        else $error("output strobe not a single pulse");
    // New data appear together with the strobe, so only strobe-free cycles hold
    a_out_hold: assert property (!out_valid |-> $stable(out_l))
        else $error("output moved without strobe");
    a_switch_at_out: assert property (!$past(srst) && $changed(deemph_on) |-> out_valid || $past(out_valid))
        else $error("processing switched off a sample boundary");
    a_switch_muted: assert property ($changed(deemph_on) || $changed(eff_on) |-> !vol_full)
        else $error("processing switched at full volume");
    a_full_settled: assert property (vol_full |-> deemph_on == deemph_req && eff_on == eff_req)
        else $error("full volume with change pending");
    a_tick_period: assert property (mod_tick && seen_q |-> gap_q == 8'(MOD_DIV - 1))
        else $error("modulator tick period wrong");
endmodule

// ---- verification/dac_effects_filter_chain_tb_top.sv ----
// Bench joining controller and filter chain over the link.
// Assumes software port timing of one-cycle strobes, read data next cycle.
`timescale 1ns/10ps
module dac_effects_filter_chain_tb_top;
    import dfx_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [7:0] sw_addr = 8'h00;
    logic [31:0] sw_wdata = 32'h00000000;
    logic [31:0] sw_rdata;
    logic [31:0] rd_q;
    logic [31:0] w;
    logic [15:0] prev = 16'h0000;
    logic [4:0] clk_div;
    logic pll_en;
    logic [2:0] pll_p;
    logic [5:0] pll_k;
    int err_total = 0;
    int checked = 0;
    int outs = 0;
    int seed = 32'h502C7D4A;
    dfx_if dfx_if_i ();
    dfx_dev #(.MOD_DIV(2)) dfx_dev_i (.ref_clk(ref_clk), .srst(srst), .lnk(dfx_if_i.dev));
    dfx_host dfx_host_i (.ref_clk(ref_clk), .srst(srst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .clk_div(clk_div), .pll_en(pll_en),
        .pll_p(pll_p), .pll_k(pll_k), .lnk(dfx_if_i.host));
    dfx_link_properties #(.MOD_DIV(2)) dfx_link_properties_i (.ref_clk(ref_clk), .srst(srst),
        .in_valid(dfx_if_i.in_valid), .out_valid(dfx_if_i.out_valid), .out_l(dfx_if_i.out_l),
        .busy(dfx_if_i.busy), .deemph_req(dfx_if_i.deemph_req), .eff_req(dfx_if_i.eff_req),
        .deemph_on(dfx_if_i.deemph_on), .eff_on(dfx_if_i.eff_on),
        .vol_full(dfx_if_i.vol_full), .mod_tick(dfx_if_i.mod_tick));
    initial forever #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (dfx_if_i.out_valid === 1'b1) outs <= outs + 1;
    function automatic logic [14:0] plan(input int q);
        case (q)
            4, 8, 9, 12, 16: plan = {q[4:0], 10'h000};
            5, 6, 7: plan = {q[4:0], 1'b1, q[2:0], 6'h10};
            10, 14: plan = {q[4:0], 1'b1, q[3:1], 6'h08};
            default: plan = 15'h0000;
        endcase
    endfunction
    // Negated sample, clipped: the edge value cannot be negated
    function automatic logic [15:0] neg_sat(input logic [15:0] x);
        neg_sat = (x == 16'h8000) ? 16'h7FFF : -x;
    endfunction
    // Two sections of gain one half each
    function automatic logic [15:0] quarter(input logic signed [15:0] x);
        quarter = x >>> 2;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge ref_clk);
        sw_rd <= 1'b0;
        #1 rd_q = sw_rdata;
        @(posedge ref_clk);
    endtask
    // Hands one stereo pair in and reads the result back
    task automatic push(input logic [31:0] d);
        int start;
        start = outs;
        wr(REG_SAMPLE, d);
        repeat (40) if (outs == start) @(posedge ref_clk);
        @(posedge ref_clk);
        rd(REG_OUT);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        rd(8'hFC);
        chk(rd_q, 32'h00000000);
        for (int q = 2; q < 18; q++) begin
            wr(REG_CLKCFG, 32'h20 | q);
            rd(REG_STATUS);
            if (plan(q) != 0) prev = {1'b0, plan(q)};
            chk({rd_q[7], clk_div, pll_en, pll_p, pll_k}, {plan(q) == 0, prev[14:0]});
        end
        for (int i = 0; i < 140; i++) begin
            w = $random(seed);
            push(w);
            if (i >= 130) chk(rd_q, w);
        end
        wr(REG_CTRL, 32'h00000001);
        wr(REG_COEF, 32'h00001234);
        rd(REG_STATUS);
        chk(rd_q, 32'h00000020);
        wr(REG_CTRL, 32'h00000000);
        rd(REG_STATUS);
        chk(rd_q, 32'h00000008);
        for (int k = 0; k < 6; k++) wr(REG_COEF, {11'h000, 5'(k < 3 ? k : k + 10),
            (k % 3 == 0) ? 16'h8000 : 16'h0000});
        wr(REG_CTRL, 32'h00000001);
        for (int i = 0; i < 280; i++) begin
            w = $random(seed);
            push(w);
            if (i >= 270) chk(rd_q, {neg_sat(w[31:16]), neg_sat(w[15:0])});
        end
        push(32'h80007FFF);
        chk(rd_q, 32'h7FFF8001);
        rd(REG_STATUS);
        chk(rd_q, 32'h00000009);
        // Ramp down and switch off, then load half-gain sections
        wr(REG_CTRL, 32'h00000000);
        for (int i = 0; i < 130; i++) push($random(seed));
        for (int a = 3; a < 26; a++) if (a % 13 >= 3) wr(REG_COEF, {11'h000, 5'(a),
            (a % 13 == 3 || a % 13 == 8) ? 16'h4000 : 16'h0000});
        wr(REG_CTRL, 32'h00000002);
        for (int i = 0; i < 140; i++) begin
            w = $random(seed);
            push(w);
            if (i >= 132) chk(rd_q, {quarter(w[31:16]), quarter(w[15:0])});
        end
        end_sim();
    end
endmodule
